/* File: lsq_host.sv */
module lsq_host (
  input  wire logic       core_clk,
  input  wire logic       en,
  input  wire logic       dim,
  input  wire logic [1:0] mode,
  output logic            enable_pin = 1'b0,
  output logic            dim_pin    = 1'b0,
  output logic            sync_pin   = 1'b0,
  output logic            sync_open  = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode_q = 2'h0;
  logic [3:0] cnt_q  = 4'h0;
  // mode 0 floating sync, 1 running sync, 2 sync shorted low
  always @(posedge core_clk) begin
    enable_pin <= en;
    dim_pin    <= dim;
    cnt_q      <= cnt_q + 4'h1;
    if (!dim_pin) begin
      mode_q <= mode;
    end
    sync_open <= (mode_q == 2'h0);
    case (mode_q)
      2'h1: sync_pin <= cnt_q[3];
      2'h2: sync_pin <= 1'b0;
      // a floating pin settles low; the open detector flags it, so no fault follows
      default: sync_pin <= 1'b0;
    endcase
  end
endmodule

/* File: lsq_pkg.sv */
package lsq_pkg;

  // ----------------------------------------------------------------
  // timing base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned CLK_NS        = 25;

  // sync pulse width floor on the far side, and the matching filter length
  localparam int unsigned SYNC_MIN_NS   = 150;
  localparam int unsigned SYNC_MIN_CYC  = (SYNC_MIN_NS + CLK_NS - 1) / CLK_NS;

  // sync lost detection windows
  localparam int unsigned SYNC_OPEN_NS  = 5000;
  localparam int unsigned SYNC_OPEN_CYC = SYNC_OPEN_NS / CLK_NS;
  localparam int unsigned SYNC_LOW_NS   = 10000;
  localparam int unsigned SYNC_LOW_CYC  = SYNC_LOW_NS / CLK_NS;

  // clock output low pulse under external sync
  localparam int unsigned LOWP_HF_NS    = 200;
  localparam int unsigned LOWP_LF_NS    = 1000;
  localparam int unsigned LOWP_HF_CYC   = LOWP_HF_NS / CLK_NS;
  localparam int unsigned LOWP_LF_CYC   = LOWP_LF_NS / CLK_NS;

  // switchover guard after a dimming rising edge (host side)
  localparam int unsigned SWO_GUARD_NS  = 500;

  // oscillator ceiling: smallest half period allowed in core cycles
  localparam int unsigned FCLAMP_KHZ    = 3500;
  localparam int unsigned FCLAMP_HALF   =
    (CLK_HZ / 1000 + 2 * FCLAMP_KHZ - 1) / (2 * FCLAMP_KHZ);

  // counts in oscillator cycles
  localparam int unsigned DET_HF_OSC    = 3584;
  localparam int unsigned DET_LF_OSC    = 832;
  localparam int unsigned OFF_HF_OSC    = 32768;

  // soft-start timer
  localparam int unsigned SS_US         = 21500;
  localparam int unsigned SS_CYC        = SS_US * (CLK_HZ / 1000000);

  localparam int unsigned NCH           = 4;
  localparam int unsigned CW            = 20;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LSQ_IDLE = 3'b000,
    LSQ_GATE = 3'b001,
    LSQ_WDIM = 3'b010,
    LSQ_DET  = 3'b011,
    LSQ_SS   = 3'b100,
    LSQ_RUN  = 3'b101,
    LSQ_FLT  = 3'b110
  } lsq_state_t;

  typedef struct packed {
    logic [NCH-1:0] above_low;
    logic [NCH-1:0] above_mid;
    logic [NCH-1:0] above_high;
    logic [NCH-1:0] in_reg;
  } lsq_led_sense_t;

  typedef struct packed {
    logic [NCH-1:0] ch_used;
    logic [NCH-1:0] ch_short;
  } lsq_led_class_t;

endpackage

/* File: lsq_props.sv */
module lsq_props (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       lf_variant,
  input wire logic       sync_open,
  input wire logic       freq_set_pin_short,
  input wire logic       freq_fault_fast,
  input wire logic [7:0] osc_half,
  input wire logic       gate_at_target,
  input wire logic       ovp_93,
  input wire logic       gate_pull_en,
  input wire logic       current_set_en,
  input wire logic       soft_start_act,
  input wire logic       boost_en,
  input wire logic       powered,
  input wire logic       fault_n,
  input wire logic       clock_output
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // length of the run of clock_output that ended on the previous sample
  logic       prev_q;
  logic [8:0] run_q;
  always_ff @(posedge core_clk) begin
    prev_q <= clock_output;
    run_q  <= (clock_output != prev_q) ? 9'h001 : run_q + 9'h001;
  end
  // ----------------------------------------
  // startup order
  // ----------------------------------------
  property p_gate; $rose(gate_pull_en) |-> powered; endproperty
  a_gate: assert property (p_gate) else $error("gate pull while unpowered");
  property p_current_set_pin; $rose(current_set_en) |-> $past(gate_at_target, 2); endproperty
  a_current_set_pin: assert property (p_current_set_pin) else $error("reference before gate target");
  sequence s_ss_end; ##[1:3] !soft_start_act; endsequence
  property p_ss; soft_start_act && ovp_93 |-> s_ss_end; endproperty
  a_ss: assert property (p_ss) else $error("soft-start kept past output level");
  // ----------------------------------------
  // clock output shape; mode switches are masked by long history windows
  // ----------------------------------------
  property p_clamp;
    $rose(clock_output) && freq_fault_fast && $past(freq_fault_fast, 8) |-> clock_output[*6];
  endproperty
  a_clamp: assert property (p_clamp) else $error("oscillator above ceiling");
  property p_half;
    $fell(clock_output) && powered && $past(powered, 250) && sync_open && fault_n
      && $past(sync_open, 250) && !freq_fault_fast && !$past(freq_fault_fast, 20)
      && osc_half == $past(osc_half, 20)
      |-> run_q == ((osc_half == 8'h00) ? 9'h001 : {1'b0, osc_half});
  endproperty
  a_half: assert property (p_half) else $error("internal clock half period wrong");
  sequence s_lowp; !clock_output[*8] ##1 clock_output; endsequence
  property p_lowp;
    $fell(clock_output) && !lf_variant && !sync_open && !$past(sync_open, 300) && fault_n
      |-> s_lowp;
  endproperty
  a_lowp: assert property (p_lowp) else $error("sync low pulse width wrong");
  // ----------------------------------------
  // sync loss and shorts
  // ----------------------------------------
  property p_open;
    sync_open && $past(sync_open, 4) && fault_n && !freq_set_pin_short |=> fault_n;
  endproperty
  a_open: assert property (p_open) else $error("fault on open sync");
  property p_stuck; !fault_n && !$past(fault_n) |-> !boost_en && !soft_start_act; endproperty
  a_stuck: assert property (p_stuck) else $error("switching during fault");
  property p_short; freq_set_pin_short[*6] |-> !boost_en; endproperty
  a_short: assert property (p_short) else $error("running with shorted set pin");
endmodule

bind lsq_seq lsq_props i_lsq_props (.core_clk, .resetn, .lf_variant, .sync_open,
  .freq_set_pin_short, .freq_fault_fast, .osc_half, .gate_at_target, .ovp_93, .gate_pull_en,
  .current_set_en, .soft_start_act, .boost_en, .powered, .fault_n, .clock_output);

/* File: lsq_seq.sv */
module lsq_seq (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   lf_variant,
  input  wire logic                   enable_pin,
  input  wire logic                   dim_pin,
  input  wire logic                   sync_pin,
  input  wire logic                   sync_open,
  input  wire logic                   freq_set_pin_ok,
  input  wire logic                   freq_set_pin_short,
  input  wire logic                   freq_fault_fast,
  input  wire logic [7:0]             osc_half,
  input  wire logic                   gate_at_target,
  input  wire logic                   ovp_93,
  input  wire lsq_pkg::lsq_led_sense_t led_sense,
  output logic                        gate_pull_en,
  output logic                        current_set_en,
  output logic                        soft_start_act,
  output logic                        boost_en,
  output logic                        powered,
  output logic                        fault_n,
  output logic                        clock_output,
  output lsq_pkg::lsq_led_class_t     led_class
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] raw_in;
  assign raw_in = {enable_pin, dim_pin, sync_pin, sync_open, freq_set_pin_ok,
                   freq_set_pin_short};

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    s1_q <= raw_in;
    s2_q <= s1_q;
  end

  logic en_s, dim_s, sy_s, syo_s, fok_s, fsh_s;
  assign {en_s, dim_s, sy_s, syo_s, fok_s, fsh_s} = s2_q;

  // led comparators are slow analog levels, synchronised as a bus
  lsq_pkg::lsq_led_sense_t ls1_q;
  lsq_pkg::lsq_led_sense_t ls2_q;
  logic                    fff1_q, fff2_q;
  always_ff @(posedge core_clk) begin
    ls1_q  <= led_sense;
    ls2_q  <= ls1_q;
    fff1_q <= freq_fault_fast;
    fff2_q <= fff1_q;
  end

  // ----------------------------------------------------------------
  // sync monitor
  // ----------------------------------------------------------------
  logic [9:0] sy_hi_q;
  logic [9:0] sy_lo_q;
  logic       sy_prev_q;
  logic       ext_q;
  logic       sync_low_flt_q;
  wire        sy_rise = sy_s & ~sy_prev_q;

  // a sync edge only sets ext_q when the low half period before it met the floor
  wire sy_valid_edge = sy_rise &&
                       (sy_lo_q >= 10'(lsq_pkg::SYNC_MIN_CYC));
  wire sy_stuck_low  = ~sy_s & ~syo_s &&
                       (sy_lo_q >= 10'(lsq_pkg::SYNC_LOW_CYC));
  wire sy_gone       = (sy_hi_q >= 10'(lsq_pkg::SYNC_OPEN_CYC)) ||
                       (syo_s && sy_lo_q >= 10'(lsq_pkg::SYNC_OPEN_CYC));

  // counters saturate so a dead sync line cannot wrap them
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sy_prev_q      <= 1'b0;
      sy_hi_q        <= '0;
      sy_lo_q        <= '0;
      ext_q          <= 1'b0;
      sync_low_flt_q <= 1'b0;
    end else begin
      sy_prev_q <= sy_s;
      sy_hi_q   <= sy_s ? (sy_hi_q == '1 ? sy_hi_q : sy_hi_q + 10'h001) : '0;
      sy_lo_q   <= sy_s ? '0 : (sy_lo_q == '1 ? sy_lo_q : sy_lo_q + 10'h001);
      if (sy_valid_edge)
        ext_q <= 1'b1;
      else if (sy_gone)
        ext_q <= 1'b0;
      if (sy_stuck_low)
        sync_low_flt_q <= 1'b1;
      else if (sy_s)
        sync_low_flt_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // internal oscillator
  // ----------------------------------------------------------------
  logic [7:0] osc_cnt_q;
  logic       osc_q;
  wire  [7:0] half_req = (osc_half == 8'h00) ? 8'h01 : osc_half;
  // fault that speeds the oscillator is held at the frequency ceiling
  wire  [7:0] half_use = (fff2_q && half_req < 8'(lsq_pkg::FCLAMP_HALF)) ?
                         8'(lsq_pkg::FCLAMP_HALF) : half_req;
  wire        osc_wrap = (osc_cnt_q >= half_use - 8'h01);
  wire        osc_tick = ext_q ? sy_rise : (osc_wrap & osc_q);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      osc_cnt_q <= '0;
      osc_q     <= 1'b0;
    end else begin
      osc_cnt_q <= osc_wrap ? 8'h00 : osc_cnt_q + 8'h01;
      if (osc_wrap)
        osc_q <= ~osc_q;
    end
  end

  // ----------------------------------------------------------------
  // power state and enable-low timer
  // ----------------------------------------------------------------
  logic [15:0] off_cnt_q;
  logic        powered_q;
  wire [15:0]  off_lim = lf_variant ? 16'h2000 : 16'(lsq_pkg::OFF_HF_OSC - 1);
  wire         turn_off = ~en_s && osc_tick && (off_cnt_q >= off_lim);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      off_cnt_q <= '0;
      powered_q <= 1'b0;
    end else begin
      if (en_s)
        off_cnt_q <= '0;
      else if (osc_tick && off_cnt_q != 16'hffff)
        off_cnt_q <= off_cnt_q + 16'h0001;
      if (en_s)
        powered_q <= 1'b1;
      else if (turn_off)
        powered_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // clock output shaping
  // ----------------------------------------------------------------
  logic [5:0] lowp_q;
  logic       clk_out_q;
  wire  [5:0] lowp_len = lf_variant ? 6'(lsq_pkg::LOWP_LF_CYC) :
                                      6'(lsq_pkg::LOWP_HF_CYC);

  // runs from power-up regardless of dimming or boost state
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lowp_q    <= '0;
      clk_out_q <= 1'b1;
    end else if (!powered_q) begin
      lowp_q    <= '0;
      clk_out_q <= 1'b1;
    end else if (ext_q) begin
      if (sy_rise)
        lowp_q <= lowp_len - 6'h01;
      else if (lowp_q != 6'h00)
        lowp_q <= lowp_q - 6'h01;
      clk_out_q <= ~(sy_rise || lowp_q != 6'h00);
    end else begin
      lowp_q    <= '0;
      clk_out_q <= osc_q;
    end
  end

  // ----------------------------------------------------------------
  // startup sequencer
  // ----------------------------------------------------------------
  lsq_pkg::lsq_state_t st_q, st_d;
  logic [11:0]           det_cnt_q;
  logic [19:0]           ss_cnt_q;
  lsq_pkg::lsq_led_class_t cls_q;

  wire freq_set_pin_bad   = fsh_s | sync_low_flt_q;
  wire freq_set_pin_ready = fok_s | ext_q;
  wire [11:0] det_lim = lf_variant ? 12'(lsq_pkg::DET_LF_OSC) :
                                     12'(lsq_pkg::DET_HF_OSC);
  wire det_go     = &ls2_q.above_low;
  wire det_done   = det_cnt_q >= det_lim;
  wire any_short  = |(~ls2_q.above_low);
  wire all_reg    = &(ls2_q.in_reg | ~cls_q.ch_used);
  // the timer runs on the core clock, never gated by dimming
  wire ss_done    = all_reg | ovp_93 |
                    (ss_cnt_q >= lsq_pkg::CW'(lsq_pkg::SS_CYC));

  // next-state selection
  always_comb begin
    st_d = st_q;
    case (st_q)
      lsq_pkg::LSQ_IDLE: if (en_s && freq_set_pin_ready && !freq_set_pin_bad) st_d = lsq_pkg::LSQ_GATE;
      lsq_pkg::LSQ_GATE: if (gate_at_target) st_d = lsq_pkg::LSQ_WDIM;
      lsq_pkg::LSQ_WDIM: if (dim_s) st_d = lsq_pkg::LSQ_DET;
      lsq_pkg::LSQ_DET:  if (det_done && !any_short) st_d = lsq_pkg::LSQ_SS;
      lsq_pkg::LSQ_SS:   if (ss_done) st_d = lsq_pkg::LSQ_RUN;
      lsq_pkg::LSQ_RUN:  st_d = lsq_pkg::LSQ_RUN;
      lsq_pkg::LSQ_FLT:  if (!freq_set_pin_bad && freq_set_pin_ready) st_d = lsq_pkg::LSQ_SS;
      default:           st_d = lsq_pkg::LSQ_IDLE;
    endcase
    if (freq_set_pin_bad && st_q != lsq_pkg::LSQ_IDLE)
      st_d = lsq_pkg::LSQ_FLT;
    if (!powered_q)
      st_d = lsq_pkg::LSQ_IDLE;
  end

  // state, detection delay in oscillator cycles, soft-start timer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q      <= lsq_pkg::LSQ_IDLE;
      det_cnt_q <= '0;
      ss_cnt_q  <= '0;
    end else begin
      st_q <= st_d;
      if (st_q != lsq_pkg::LSQ_DET || !det_go)
        det_cnt_q <= '0;
      else if (osc_tick && !det_done)
        det_cnt_q <= det_cnt_q + 12'h001;
      ss_cnt_q <= (st_q == lsq_pkg::LSQ_SS) ? ss_cnt_q + 20'h00001 : '0;
    end
  end

  // channel classification latched at the close of detection
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cls_q <= '0;
    end else if (st_q == lsq_pkg::LSQ_IDLE) begin
      cls_q <= '0;
    end else if (st_q == lsq_pkg::LSQ_DET) begin
      cls_q.ch_used  <= ls2_q.above_high;
      cls_q.ch_short <= ~ls2_q.above_low;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      gate_pull_en   <= 1'b0;
      current_set_en <= 1'b0;
      soft_start_act <= 1'b0;
      boost_en       <= 1'b0;
      powered        <= 1'b0;
      fault_n        <= 1'b1;
      clock_output   <= 1'b1;
      led_class      <= '0;
    end else begin
      gate_pull_en   <= (st_q != lsq_pkg::LSQ_IDLE);
      current_set_en <= (st_q != lsq_pkg::LSQ_IDLE) && (st_q != lsq_pkg::LSQ_GATE);
      soft_start_act <= (st_q == lsq_pkg::LSQ_SS);
      boost_en       <= ((st_q == lsq_pkg::LSQ_SS) || (st_q == lsq_pkg::LSQ_RUN)) && dim_s;
      powered        <= powered_q;
      fault_n        <= (st_q != lsq_pkg::LSQ_FLT) || !sync_low_flt_q && !fsh_s;
      clock_output   <= clk_out_q;
      led_class      <= cls_q;
    end
  end

endmodule

/* File: tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    core_clk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    en = 1'b0;
  logic                    dim = 1'b0;
  logic [1:0]              mode = 2'h0;
  logic                    freq_set_pin_ok = 1'b0;
  logic                    freq_set_pin_short = 1'b0;
  logic                    freq_fault_fast = 1'b0;
  logic                    gate_at_target = 1'b0;
  logic                    ovp_93 = 1'b0;
  logic [7:0]              osc_half = 8'h04;
  lsq_pkg::lsq_led_sense_t led_sense = 16'h0000;
  logic                    enable_pin, dim_pin, sync_pin, sync_open, gate_pull_en;
  logic                    current_set_en, soft_start_act, boost_en, powered, fault_n;
  logic                    clock_output;
  lsq_pkg::lsq_led_class_t led_class;
  int                      err_count = 0;
  int                      n_compared = 0;
  int                      seed = 20;
  int                      n;
  lsq_host i_lsq_host (.core_clk, .en, .dim, .mode, .enable_pin, .dim_pin, .sync_pin, .sync_open);
  lsq_seq i_lsq_seq (.core_clk, .resetn, .lf_variant(1'b0), .enable_pin, .dim_pin, .sync_pin,
    .sync_open, .freq_set_pin_ok, .freq_set_pin_short, .freq_fault_fast, .osc_half,
    .gate_at_target, .ovp_93, .led_sense, .gate_pull_en, .current_set_en, .soft_start_act,
    .boost_en, .powered, .fault_n, .clock_output, .led_class);
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected half period: zero reads as one, a fault clamps to the ceiling
  function automatic int hf(input int h, input bit f);
    int e;
    e = (h == 0) ? 1 : h;
    return (f && e < lsq_pkg::FCLAMP_HALF) ? lsq_pkg::FCLAMP_HALF : e;
  endfunction
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // sampling on the falling edge keeps clear of the design's own updates
  task automatic wt(ref logic s, input logic v, input int lim, output int k);
    for (k = 0; k < lim && s !== v; k++) @(negedge core_clk);
  endtask
  task automatic run(input logic lv, output int k);
    k = 0;
    for (int i = 0; i < 400 && clock_output === lv; i++) @(negedge core_clk);
    for (int i = 0; i < 400 && clock_output !== lv; i++) @(negedge core_clk);
    while (clock_output === lv && k < 400) begin
      k++;
      @(negedge core_clk);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    cyc(60000);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    cyc(12);
    resetn <= 1'b1;
    @(negedge core_clk);
    chk(fault_n === 1'b1 && clock_output === 1'b1 && led_class === 8'h00, "reset values");
    @(posedge core_clk);
    en <= 1'b1;
    cyc(40);
    chk(gate_pull_en === 1'b0, "started with set pin low");
    // ----------------------------------------
    // internal clock with dimming low, random half periods, then clamped
    // ----------------------------------------
    for (int i = 0; i < 3; i++) begin
      osc_half <= 8'((xs() & 7) + 2);
      cyc(40);
      run(1'b1, n);
      chk(n == hf(osc_half, 1'b0), "clock high run");
    end
    freq_fault_fast <= 1'b1;
    osc_half <= 8'h01;
    cyc(20);
    run(1'b1, n);
    chk(n == hf(1, 1'b1), "clamped high run");
    @(posedge core_clk);
    freq_fault_fast <= 1'b0;
    freq_set_pin_ok <= 1'b1;
    wt(gate_pull_en, 1'b1, 20, n);
    chk(gate_pull_en === 1'b1, "gate pull missing");
    cyc(20);
    chk(current_set_en === 1'b0, "reference too early");
    gate_at_target <= 1'b1;
    wt(current_set_en, 1'b1, 10, n);
    chk(current_set_en === 1'b1, "reference missing");
    // ----------------------------------------
    // detection held by a shorted sink, then counted from release
    // ----------------------------------------
    led_sense <= 16'hbf70;
    dim <= 1'b1;
    cyc(8000);
    chk(soft_start_act === 1'b0, "soft-start over a shorted sink");
    led_sense <= 16'hff70;
    wt(soft_start_act, 1'b1, 8000, n);
    chk(n >= 2 * lsq_pkg::DET_HF_OSC && n <= 2 * lsq_pkg::DET_HF_OSC + 10, "detect time");
    chk(led_class === 8'h70 && boost_en === 1'b1, "sink classes");
    cyc(50);
    chk(soft_start_act === 1'b1, "soft-start ended early");
    ovp_93 <= 1'b1;
    wt(soft_start_act, 1'b0, 5, n);
    chk(soft_start_act === 1'b0, "soft-start not ended");
    // ----------------------------------------
    // external sync, stuck low, recovery, open, short
    // ----------------------------------------
    dim <= 1'b0;
    ovp_93 <= 1'b0;
    cyc(3);
    mode <= 2'h1;
    cyc(320);
    run(1'b0, n);
    chk(n == lsq_pkg::LOWP_HF_CYC, "sync low pulse");
    mode <= 2'h2;
    wt(fault_n, 1'b0, 500, n);
    chk(fault_n === 1'b0 && n >= lsq_pkg::SYNC_LOW_CYC - 20, "stuck sync fault");
    mode <= 2'h1;
    wt(fault_n, 1'b1, 100, n);
    chk(fault_n === 1'b1, "fault not cleared");
    wt(soft_start_act, 1'b1, 20, n);
    chk(soft_start_act === 1'b1, "no soft-start after release");
    mode <= 2'h0;
    dim <= 1'b1;
    cyc(300);
    run(1'b1, n);
    chk(n == hf(1, 1'b0) && fault_n === 1'b1, "open sync fallback");
    chk(boost_en === 1'b1, "boost off before short");
    freq_set_pin_short <= 1'b1;
    cyc(10);
    chk(boost_en === 1'b0, "short not shut down");
    end_of_test();
  end
endmodule
